/* File: design/stall_adapt_defs.vh */
`ifndef STALL_ADAPT_DEFS_VH
`define STALL_ADAPT_DEFS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONFIG      8'h00
`define OFS_CURRENT     8'h04
`define OFS_SPEED       8'h08
`define OFS_STATUS      8'h0c
`define OFS_INT_STATUS  8'h10
`define OFS_INT_MASK    8'h14

// ----------------------------------------------------------------------------
// axi4-lite responses
// ----------------------------------------------------------------------------
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// ----------------------------------------------------------------------------
// config register fields
// ----------------------------------------------------------------------------
`define CFG_STALL_THR   7:0
`define CFG_LOWER       11:8
`define CFG_HYST        15:12
`define CFG_INC_SEL     17:16
`define CFG_DEC_SEL     19:18
`define CFG_MIN_SEL     20
`define CFG_RESET       21'h000000

// ----------------------------------------------------------------------------
// current register fields
// ----------------------------------------------------------------------------
`define CUR_RUN         4:0
`define CUR_HOLD        12:8
`define RST_RUN         5'h1f
`define RST_HOLD        5'h10

// ----------------------------------------------------------------------------
// speed register and step interval
// ----------------------------------------------------------------------------
`define SPEED_W         20
`define RST_SPEED       20'h00000

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define ST_LOAD         7:0
`define ST_ACTUAL       12:8
`define ST_COIL         20:16
`define ST_SPEED_OK     24
`define ST_ADAPT_ON     25

// ----------------------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------------------
`define INT_W           3
`define INT_STALL       0
`define INT_UPDATE      1
`define INT_CUR_UP      2
`define INT_RESET       3'h0

// ----------------------------------------------------------------------------
// sequencer position and adaptive control constants
// ----------------------------------------------------------------------------
`define POS_W           10
`define POS_QUAD        9:8
`define QUAD_INDEX      2'h0
`define THR_SHIFT       5
`define DN_CNT0         6'h20
`define DN_CNT1         6'h08
`define DN_CNT2         6'h02
`define DN_CNT3         6'h01

`endif

/* File: design/adaptive_current.v */
`timescale 1ns/1ns
`include "stall_adapt_defs.vh"

module adaptive_current (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       clk_en,
	input  wire       sample,
	input  wire [7:0] load,
	input  wire       enable,
	input  wire [3:0] lower_sel,
	input  wire [3:0] hyst_sel,
	input  wire [1:0] inc_sel,
	input  wire [1:0] dec_sel,
	input  wire       min_sel,
	input  wire [4:0] run_scale,
	output reg  [4:0] actual,
	output reg        inc_event
);

	// scale a threshold code by 32 onto the 10-bit compare range
	function [9:0] scale32;
		input [4:0] code;
		begin
			scale32 = {code, 5'h00} >> (5 - `THR_SHIFT);
		end
	endfunction

	wire [9:0] load10    = {2'b00, load};
	wire [9:0] lower_thr = scale32({1'b0, lower_sel});
	wire [9:0] upper_thr = scale32({1'b0, lower_sel} + {1'b0, hyst_sel} + 5'h01);
	wire [5:0] run_p1    = {1'b0, run_scale} + 6'h01;
	wire [5:0] half      = min_sel ? (run_p1 >> 2) : (run_p1 >> 1);
	wire [4:0] floor_sc  = (half == 6'h00) ? 5'h00 : half[4:0] - 5'h01;
	wire [5:0] inc_amt   = 6'h01 << inc_sel;
	wire [5:0] inc_sum   = {1'b0, actual} + inc_amt;
	reg  [5:0] dn_need;
	reg  [5:0] cnt;

	// samples at or above the upper threshold needed per decrement
	always @* begin
		case (dec_sel)
			2'h0:    dn_need = `DN_CNT0;
			2'h1:    dn_need = `DN_CNT1;
			2'h2:    dn_need = `DN_CNT2;
			default: dn_need = `DN_CNT3;
		endcase
	end

	// current scale regulation between floor and run current
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			actual    <= `RST_RUN;
			cnt       <= 6'h00;
			inc_event <= 1'b0;
		end else if (clk_en) begin
			inc_event <= 1'b0;
			if (!enable) begin
				actual <= run_scale;
				cnt    <= 6'h00;
			end else if (sample) begin
				if (load10 < lower_thr) begin
					actual    <= (inc_sum > {1'b0, run_scale}) ? run_scale : inc_sum[4:0];
					cnt       <= 6'h00;
					inc_event <= 1'b1;
				end else if (load10 >= upper_thr) begin
					if (cnt + 6'h01 >= dn_need) begin
						actual <= (actual > floor_sc) ? actual - 5'h01 : floor_sc;
						cnt    <= 6'h00;
					end else begin
						cnt <= cnt + 6'h01;
					end
				end else begin
					cnt <= 6'h00;
				end
			end else if (actual > run_scale) begin
				actual <= run_scale;
			end else if (actual < floor_sc) begin
				actual <= floor_sc;
			end
		end
	end

endmodule

/* File: design/stall_detect_adaptive_current.v */
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "stall_adapt_defs.vh"

// Overview of operation
// - load value refreshed once per full step at a half-step crossing, held between.
// - one refresh instant coincides with the index pulse sequencer position.
// - load measurement value has eight bits of resolution.
// - fresh load value below stall limit pulses the diagnostic output.
// - stall limit is twice the programmed stall threshold.
// - stall pulse only in quiet chopper mode with speed threshold >= step interval.
// - four-bit lower threshold; load below it raises current of both coils.
// - lower threshold used in comparison is setting times 32.
// - samples at or above upper threshold counted; enough of them decrement current.
// - increment step select gives 1, 2, 4 or 8 per low sample.
// - decrement rate select needs 32, 8, 2 or 1 high samples per decrement.
// - minimum current select gives floor of half or quarter of run current.
// - adaptive control off below the minimum speed threshold.
// - actual current scale is five bits, bounded by run current and floor.
// - below speed threshold coil current follows run or hold scale.

module stall_detect_adaptive_current (
	input  wire                 mclk,
	input  wire                 rst_n,
	input  wire                 clk_en,
	// sequencer and measurement side, same clock
	input  wire [`POS_W-1:0]    microstep_position,
	input  wire [7:0]           load_measure_raw,
	input  wire [`SPEED_W-1:0]  measured_step_interval,
	input  wire                 quiet_chopper_active,
	input  wire                 standstill,
	// outputs to motor and controller
	output reg                  diagnostic_output,
	output reg                  index_pulse,
	output reg  [4:0]           coil_current_scale,
	output wire                 irq,
	// axi4-lite slave
	input  wire [7:0]           s_axi_awaddr,
	input  wire [2:0]           s_axi_awprot,
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	output reg  [1:0]           s_axi_bresp,
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [7:0]           s_axi_araddr,
	input  wire [2:0]           s_axi_arprot,
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	output reg  [31:0]          s_axi_rdata,
	output reg  [1:0]           s_axi_rresp,
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready
);

	// ------------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------------
	// register storage and internal strobes
	reg  [20:0]          config_reg;
	reg  [4:0]           run_current_scale;
	reg  [4:0]           hold_current_scale;
	reg  [`SPEED_W-1:0]  adaptive_min_speed_threshold;
	reg  [`INT_W-1:0]    int_status;
	reg  [`INT_W-1:0]    int_mask;
	reg  [7:0]           load_measure_value;
	reg  [1:0]           prev_quad;
	reg                  sample_pulse;
	reg                  update_pulse;
	wire [4:0]           actual_current_scale;
	wire                 cur_up_event;

	// fields of the config register
	wire [7:0] stall_threshold         = config_reg[`CFG_STALL_THR];
	wire [3:0] lower_load_threshold    = config_reg[`CFG_LOWER];
	wire [3:0] upper_load_hysteresis   = config_reg[`CFG_HYST];
	wire [1:0] increment_step_select   = config_reg[`CFG_INC_SEL];
	wire [1:0] decrement_rate_select   = config_reg[`CFG_DEC_SEL];
	wire       min_current_select      = config_reg[`CFG_MIN_SEL];

	// ------------------------------------------------------------------------
	// write channel state
	// ------------------------------------------------------------------------
	reg        aw_held;
	reg [7:0]  aw_addr;
	reg        w_held;
	reg [31:0] w_data;
	reg [3:0]  w_strb;

	// byte lane merge for a register write
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// decode a byte address into mapped or not
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_CONFIG) || (a == `OFS_CURRENT) || (a == `OFS_SPEED) ||
			         (a == `OFS_STATUS) || (a == `OFS_INT_STATUS) || (a == `OFS_INT_MASK);
		end
	endfunction

	// handshakes stall while frozen or while a response is pending
	assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = clk_en && !w_held && !s_axi_bvalid;

	// handshakes and the write request taken from either side
	wire       aw_now   = s_axi_awvalid && s_axi_awready;
	wire       w_now    = s_axi_wvalid && s_axi_wready;
	wire       have_aw  = aw_held || aw_now;
	wire       have_w   = w_held || w_now;
	wire [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb  = w_held ? w_strb : s_axi_wstrb;
	wire       wr_fire  = clk_en && have_aw && have_w && !s_axi_bvalid;
	wire [1:0] wr_resp  = mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;

	// capture address and data in either order, answer when both are in
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held      <= 1'b0;
			aw_addr      <= 8'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (clk_en) begin
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_resp;
			end else begin
				if (aw_now) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (w_now) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// software writable registers
	// ------------------------------------------------------------------------
	// write data merged over the present contents
	wire [31:0] cfg_word = merge({11'h000, config_reg}, wr_data, wr_strb);
	wire [31:0] cur_word = merge({19'h00000, hold_current_scale, 3'h0, run_current_scale}, wr_data, wr_strb);
	wire [31:0] spd_word = merge({12'h000, adaptive_min_speed_threshold}, wr_data, wr_strb);
	wire [31:0] msk_word = merge({29'h00000000, int_mask}, wr_data, wr_strb);

	// register writes steer thresholds, selections and currents
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			config_reg                   <= `CFG_RESET;
			run_current_scale            <= `RST_RUN;
			hold_current_scale           <= `RST_HOLD;
			adaptive_min_speed_threshold <= `RST_SPEED;
			int_mask                     <= `INT_RESET;
		end else if (clk_en && wr_fire) begin
			case (wr_addr)
				`OFS_CONFIG:   config_reg <= cfg_word[20:0];
				`OFS_CURRENT: begin
					run_current_scale  <= cur_word[`CUR_RUN];
					hold_current_scale <= cur_word[`CUR_HOLD];
				end
				`OFS_SPEED:    adaptive_min_speed_threshold <= spd_word[`SPEED_W-1:0];
				`OFS_INT_MASK: int_mask <= msk_word[`INT_W-1:0];
				default:       ;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------------------
	assign s_axi_arready = clk_en && !s_axi_rvalid;

	// read handshake and the speed gate for stall and adaptive control
	wire ar_now      = s_axi_arvalid && s_axi_arready;
	wire [1:0] rd_resp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
	wire speed_ok    = adaptive_min_speed_threshold >= measured_step_interval;
	wire adapt_on    = speed_ok && (lower_load_threshold != 4'h0);
	reg  [31:0] rd_word;

	// read multiplexer, status shows the block's own state
	always @* begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`OFS_CONFIG:     rd_word[20:0] = config_reg;
			`OFS_CURRENT: begin
				rd_word[`CUR_RUN]  = run_current_scale;
				rd_word[`CUR_HOLD] = hold_current_scale;
			end
			`OFS_SPEED:      rd_word[`SPEED_W-1:0] = adaptive_min_speed_threshold;
			`OFS_STATUS: begin
				rd_word[`ST_LOAD]     = load_measure_value;
				rd_word[`ST_ACTUAL]   = actual_current_scale;
				rd_word[`ST_COIL]     = coil_current_scale;
				rd_word[`ST_SPEED_OK] = speed_ok;
				rd_word[`ST_ADAPT_ON] = adapt_on;
			end
			`OFS_INT_STATUS: rd_word[`INT_W-1:0] = int_status;
			`OFS_INT_MASK:   rd_word[`INT_W-1:0] = int_mask;
			default:         rd_word = 32'h0000_0000;
		endcase
	end

	// registered read answer, one cycle after the address is taken
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (clk_en) begin
			if (ar_now) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_resp;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// load measurement update
	// ------------------------------------------------------------------------
	// half-step crossing, index position and the stall limit check
	wire [1:0] quad       = microstep_position[`POS_QUAD];
	wire       step_cross = (quad != prev_quad);
	wire       stall_hit  = {1'b0, load_measure_raw} < {stall_threshold, 1'b0};
	wire       index_hit  = step_cross && (quad == `QUAD_INDEX);
	wire       stall_fire = step_cross && stall_hit && quiet_chopper_active && speed_ok;

	// refresh once per full step and flag the sample for the controller
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prev_quad          <= `QUAD_INDEX;
			load_measure_value <= 8'h00;
			sample_pulse       <= 1'b0;
			update_pulse       <= 1'b0;
			index_pulse        <= 1'b0;
			diagnostic_output  <= 1'b0;
		end else if (clk_en) begin
			prev_quad    <= quad;
			sample_pulse <= step_cross;
			update_pulse <= step_cross;
			index_pulse  <= index_hit;
			if (step_cross)
				load_measure_value <= load_measure_raw;
			diagnostic_output <= stall_fire;
		end
	end

	// ------------------------------------------------------------------------
	// adaptive current controller
	// ------------------------------------------------------------------------
	adaptive_current u_adapt (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.sample    (sample_pulse),
		.load      (load_measure_value),
		.enable    (adapt_on),
		.lower_sel (lower_load_threshold),
		.hyst_sel  (upper_load_hysteresis),
		.inc_sel   (increment_step_select),
		.dec_sel   (decrement_rate_select),
		.min_sel   (min_current_select),
		.run_scale (run_current_scale),
		.actual    (actual_current_scale),
		.inc_event (cur_up_event)
	);

	reg  [4:0] next_coil_scale;

	// coil current follows hold scale at standstill, else actual scale when adaptive control is on, else run scale
	always @* begin
		if (standstill)
			next_coil_scale = hold_current_scale;
		else if (adapt_on)
			next_coil_scale = actual_current_scale;
		else
			next_coil_scale = run_current_scale;
	end

	// coil scale register
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			coil_current_scale <= `RST_RUN;
		else if (clk_en)
			coil_current_scale <= next_coil_scale;
	end

	// ------------------------------------------------------------------------
	// interrupts: sticky, cleared by read, a new event wins over the clear
	// ------------------------------------------------------------------------
	// event vector and read-clear strobe
	wire [`INT_W-1:0] int_events = {cur_up_event, update_pulse, diagnostic_output};
	wire              int_rd_clr = ar_now && (s_axi_araddr == `OFS_INT_STATUS);

	reg  [`INT_W-1:0] next_int_status;

	// read clears the status, an event in the same cycle sets it again
	always @* begin
		next_int_status = int_status;
		if (int_rd_clr)
			next_int_status = {`INT_W{1'b0}};
		next_int_status = next_int_status | int_events;
	end

	// status bits collect events
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			int_status <= `INT_RESET;
		else if (clk_en)
			int_status <= next_int_status;
	end

	assign irq = |(int_status & int_mask);

endmodule

/* File: dv/stall_adapt_monitor.sv */
`timescale 1ns/1ns

module stall_adapt_monitor (
	input wire        mclk,
	input wire        rst_n,
	input wire        clk_en,
	input wire [9:0]  microstep_position,
	input wire        quiet_chopper_active,
	input wire        diagnostic_output,
	input wire        index_pulse,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready
);
	reg  [1:0] prev_q;
	wire       upd;

	// quadrant seen at the last enabled edge
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			prev_q <= 2'h0;
		else if (clk_en)
			prev_q <= microstep_position[9:8];
	end
	assign upd = clk_en && (microstep_position[9:8] != prev_q); // half-step crossing

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// bus handshakes
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	a_no_update_quiet: assert property (clk_en && !upd |=> !diagnostic_output && !index_pulse)
		else $error("pulse without quadrant change");
	a_index_quadrant: assert property (upd |=> index_pulse == ($past(microstep_position[9:8]) == 2'h0))
		else $error("index pulse wrong at update");
	a_stall_mode: assert property (diagnostic_output && $past(clk_en) |-> $past(upd) && $past(quiet_chopper_active))
		else $error("stall pulse outside quiet mode update");
	a_frozen_ready: assert property (!clk_en |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while frozen");
	a_arready_rule: assert property (s_axi_arready == (clk_en && !s_axi_rvalid))
		else $error("arready wrong");
	a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_write_answer: assert property (aw_w_taken |=> s_axi_bvalid)
		else $error("write answer late");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
		else $error("error read data not zero");
endmodule

/* File: dv/motion_ctrl_model.sv */
`timescale 1ns/1ns

module motion_ctrl_model (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       step_req,
	input  wire       stop_on_stall,
	input  wire       diagnostic_output,
	output reg  [9:0] microstep_position
);
	reg stopped;

	// one full step per request from a full-step table position; halt after a stall pulse while stop_on_stall is set
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			microstep_position <= 10'h080;
			stopped <= 1'b0;
		end else begin
			if (diagnostic_output && stop_on_stall)
				stopped <= 1'b1;
			if (step_req && !stopped)
				microstep_position <= microstep_position + 10'h100;
		end
	end
endmodule

/* File: dv/stall_detect_adaptive_current_test.sv */
`timescale 1ns/1ns
`include "stall_adapt_defs.vh"

module stall_detect_adaptive_current_test;
	reg         mclk, rst_n, clk_en, quiet, standstill, step_req;
	reg  [7:0]  load_raw, awa, ara, thr;
	reg  [19:0] interval;
	reg         awv, wv, br, arv, rr, mins, stop;
	reg  [31:0] wd, lfsr, rdv;
	reg  [3:0]  lower, hyst;
	reg  [1:0]  incs, decs, rsp;
	wire [9:0]  pos;
	wire        stall_p, idx, irq, awr, wr, bv, arr, rv;
	wire [4:0]  coil;
	wire [1:0]  brsp, rrsp;
	wire [31:0] rd;
	integer     fail_count, checks_done, nst, nidx, c, i, q, act, cnt, spd, fl, need, ns0;

	stall_detect_adaptive_current i_stall_detect_adaptive_current (
		.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .microstep_position(pos),
		.load_measure_raw(load_raw), .measured_step_interval(interval), .quiet_chopper_active(quiet),
		.standstill(standstill), .diagnostic_output(stall_p), .index_pulse(idx),
		.coil_current_scale(coil), .irq(irq), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(brsp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(rr)
	);
	motion_ctrl_model i_motion_ctrl_model (.mclk(mclk), .rst_n(rst_n), .step_req(step_req),
		.stop_on_stall(stop), .diagnostic_output(stall_p), .microstep_position(pos));

	// clock and pulse counters
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (stall_p === 1'b1) nst = nst + 1;
		if (idx === 1'b1) nidx = nidx + 1;
	end

	function [31:0] lfsr_next(input [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input [8*8:1] nm, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask

	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	// write with both channels offered together, bready held until the answer
	task axi_wr(input [7:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge mclk);
			awa <= a;
			wd <= d;
			awv <= 1'b1;
			wv <= 1'b1;
			br <= 1'b1;
			for (k = 0; k < 64; k = k + 1) begin
				@(posedge mclk);
				if (awv && awr) awv <= 1'b0;
				if (wv && wr) wv <= 1'b0;
				if (bv) begin
					rsp = brsp;
					br <= 1'b0;
					k = 99;
				end
			end
			if (k != 100) begin
				fail_count = fail_count + 1;
				end_of_test;
			end
		end
	endtask

	// read, rready held until rvalid
	task axi_rd(input [7:0] a);
		integer k;
		begin
			@(posedge mclk);
			ara <= a;
			arv <= 1'b1;
			rr <= 1'b1;
			for (k = 0; k < 64; k = k + 1) begin
				@(posedge mclk);
				if (arv && arr) arv <= 1'b0;
				if (rv) begin
					rdv = rd;
					rsp = rrsp;
					rr <= 1'b0;
					k = 99;
				end
			end
			if (k != 100) begin
				fail_count = fail_count + 1;
				end_of_test;
			end
		end
	endtask

	// one full step with a given load, then the reference model of stall and current control
	task step(input [7:0] ld);
		integer n0, i0, ok;
		begin
			n0 = nst;
			i0 = nidx;
			@(posedge mclk);
			load_raw <= ld;
			step_req <= 1'b1;
			@(posedge mclk);
			step_req <= 1'b0;
			repeat (6) @(posedge mclk);
			q = (q + 1) % 4;
			ok = (spd >= interval);
			chk("stall", nst - n0, quiet && ok && ld < 2 * thr);
			chk("index", nidx - i0, q == 0);
			fl = (32 >> (mins ? 2 : 1)) - 1;
			need = (decs == 0) ? 32 : (decs == 1) ? 8 : (decs == 2) ? 2 : 1;
			cnt = cnt + 1;
			if (lower == 0 || !ok) begin
				act = 31;
				cnt = 0;
			end else if (ld < lower * 32) begin
				act = (act + (1 << incs) > 31) ? 31 : act + (1 << incs);
				cnt = 0;
			end else if (ld < (lower + hyst + 1) * 32)
				cnt = 0;
			else if (cnt >= need) begin
				act = (act - 1 < fl) ? fl : act - 1;
				cnt = 0;
			end
			chk("coil", coil, act);
		end
	endtask

	initial begin
		{rst_n, clk_en, quiet, standstill, step_req, awv, wv, br, arv, rr, stop} = 11'h200;
		{load_raw, awa, ara, wd, interval, thr, lower, hyst, incs, decs, mins} = 0;
		{fail_count, checks_done, nst, nidx, q, cnt, spd} = 0;
		lfsr = 32'h79496333;
		act = 31;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		axi_rd(`OFS_CONFIG);
		chk("config", rdv, 32'h0);
		axi_rd(`OFS_CURRENT);
		chk("current", rdv, 32'h101f);
		axi_rd(`OFS_INT_MASK);
		chk("mask", rdv, 32'h0);
		axi_rd(8'h18);
		chk("rd_unmap", rsp, `RESP_SLVERR);
		axi_wr(8'h1c, 32'h1);
		chk("wr_unmap", rsp, `RESP_SLVERR);
		axi_wr(`OFS_INT_MASK, 32'h7);
		spd = 32'h800;
		axi_wr(`OFS_SPEED, spd);
		// every increment and decrement code, both floors, control off by setting and by speed
		for (c = 0; c < 16; c = c + 1) begin
			lfsr = lfsr_next(lfsr);
			thr = lfsr[7:0] | 8'h01;
			ns0 = nst;
			lower = (c == 13) ? 4'h0 : 4'h2;
			hyst = c % 3;
			incs = c % 4;
			decs = (c / 4) % 4;
			mins = (c >= 8);
			quiet <= c % 2;
			interval <= (c == 14) ? 20'h01000 : 20'h00100;
			axi_wr(`OFS_CONFIG, {11'h0, mins, decs, incs, hyst, lower, thr});
			clk_en <= 1'b0;
			repeat (3) @(posedge mclk);
			clk_en <= 1'b1;
			for (i = 0; i < 40; i = i + 1) begin
				lfsr = lfsr_next(lfsr);
				step((i < 34) ? (8'hc0 | lfsr[5:0]) : lfsr[7:0]);
			end
			axi_rd(`OFS_STATUS);
			chk("load", rdv[7:0], load_raw);
			chk("actual", rdv[12:8], act);
			chk("irq_on", irq, 1'b1);
			axi_rd(`OFS_INT_STATUS);
			chk("int_upd", rdv[1], 1'b1);
			chk("int_stl", rdv[0], nst != ns0);
			repeat (2) @(posedge mclk);
			chk("irq_clr", irq, 1'b0);
		end
		axi_wr(`OFS_INT_MASK, 32'h0);
		stop <= 1'b1;
		step(8'h00);
		chk("irq_mask", irq, 1'b0);
		standstill <= 1'b1;
		step_req <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("hold", coil, 5'h10);
		chk("stopped", pos, q * 256 + 128);
		end_of_test;
	end
endmodule

bind stall_detect_adaptive_current stall_adapt_monitor i_stall_adapt_monitor (
	.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .microstep_position(microstep_position),
	.quiet_chopper_active(quiet_chopper_active), .diagnostic_output(diagnostic_output),
	.index_pulse(index_pulse), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
